// [fcsr_core.sv]
/*
 Command interpreter of a partitioned parallel flash: one chip-wide write
 state machine, per-partition output selectors, array operation requests.
 Assumes bus writes arrive synchronous to i_clk, one cycle each, and the
 array controller reports busy and done on the same clock.
*/
`timescale 1ns/1ps
module fcsr_core (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire fcsr_pkg::fcsr_write_type i_write,
    input wire logic i_array_busy,
    input wire logic i_array_done,
    input wire logic [3:0] i_array_err,
    input wire logic i_factory_status_bit,
    input wire logic [fcsr_pkg::ADDR_BITS-1:0] i_read_addr,
    output fcsr_pkg::fcsr_req_type o_req,
    output logic [3:0] o_err,
    output logic o_idle,
    output logic o_read_valid,
    output fcsr_pkg::fcsr_out_type o_read_sel,
    output logic o_read_query
);
    typedef enum logic [3:0] {
        FCSR_READY,
        FCSR_PROG_SETUP,
        FCSR_ERASE_SETUP,
        FCSR_FACTORY_SETUP,
        FCSR_FACTORY_BUSY,
        FCSR_OTP_SETUP,
        FCSR_LOCK_SETUP,
        FCSR_BUSY,
        FCSR_PROG_SUSP,
        FCSR_PROG_SUSP_ERASE_SETUP
    } fcsr_state_type;

    fcsr_state_type state_q;
    fcsr_state_type state_d;
    fcsr_pkg::fcsr_out_type sel_q [fcsr_pkg::PARTS];
    fcsr_pkg::fcsr_req_type req_d;
    fcsr_pkg::fcsr_req_type req_q;
    logic [fcsr_pkg::ADDR_BITS-1:0] first_cycle_block_address_q;
    logic [3:0] err_q;
    logic read_valid_q;
    fcsr_pkg::fcsr_out_type read_sel_q;
    logic read_query_q;
    logic [fcsr_pkg::PART_BITS-1:0] last_part_q;
    logic idle_q;

    wire logic [7:0] code;
    wire logic legal;
    wire logic [fcsr_pkg::PART_BITS-1:0] wr_part;
    wire logic [fcsr_pkg::PART_BITS-1:0] rd_part;
    wire logic machine_busy;
    wire logic clear_ok;
    wire logic factory_accept;
    wire logic in_setup;
    wire logic [fcsr_pkg::ADDR_BITS-1:0] blk_addr;

    function automatic logic [fcsr_pkg::PART_BITS-1:0] part_of(
        input logic [fcsr_pkg::ADDR_BITS-1:0] a);
        part_of = a[fcsr_pkg::ADDR_BITS-1 -: fcsr_pkg::PART_BITS];
    endfunction

    fcsr_cmd_decode u_decode (
        .i_code(code),
        .o_legal(legal)
    );

    assign code = i_write.data[7:0];
    assign wr_part = part_of(i_write.addr);
    assign rd_part = part_of(i_read_addr);
    assign blk_addr = {i_write.addr[fcsr_pkg::ADDR_BITS-1:fcsr_pkg::BLOCK_LSB],
                       {fcsr_pkg::BLOCK_LSB{1'b0}}};
    assign machine_busy = (state_q == FCSR_BUSY) ||
                          (state_q == FCSR_FACTORY_BUSY);
    assign clear_ok = !machine_busy && !i_array_busy;
    assign factory_accept = (state_q == FCSR_FACTORY_BUSY) &&
                            !i_factory_status_bit;
    // Second cycles and factory data always point at status
    assign in_setup = (state_q == FCSR_PROG_SETUP) ||
                      (state_q == FCSR_ERASE_SETUP) ||
                      (state_q == FCSR_FACTORY_SETUP) ||
                      (state_q == FCSR_FACTORY_BUSY) ||
                      (state_q == FCSR_OTP_SETUP) ||
                      (state_q == FCSR_LOCK_SETUP) ||
                      (state_q == FCSR_PROG_SUSP_ERASE_SETUP);

    // Chip-wide next state, never looks at the selectors
    always_comb begin
        state_d = state_q;
        req_d = '0;
        req_d.block_addr = first_cycle_block_address_q;
        req_d.addr = i_write.addr;
        req_d.data = i_write.data;
        if (i_write.valid) begin
            case (state_q)
                FCSR_READY: begin
                    case (code)
                        fcsr_pkg::CMD_PROGRAM,
                        fcsr_pkg::CMD_PROGRAM_ALT: state_d = FCSR_PROG_SETUP;
                        fcsr_pkg::CMD_ERASE: state_d = FCSR_ERASE_SETUP;
                        fcsr_pkg::CMD_FACTORY: state_d = FCSR_FACTORY_SETUP;
                        fcsr_pkg::CMD_OTP_SETUP: state_d = FCSR_OTP_SETUP;
                        fcsr_pkg::CMD_LOCK_SETUP: state_d = FCSR_LOCK_SETUP;
                        default: state_d = FCSR_READY;
                    endcase
                end
                FCSR_PROG_SETUP: begin
                    req_d.valid = 1'b1;
                    req_d.op = fcsr_pkg::FCSR_OP_PROGRAM;
                    state_d = FCSR_BUSY;
                end
                FCSR_OTP_SETUP: begin
                    req_d.valid = 1'b1;
                    req_d.op = fcsr_pkg::FCSR_OP_OTP;
                    state_d = FCSR_BUSY;
                end
                FCSR_ERASE_SETUP: begin
                    if (code == fcsr_pkg::CMD_CONFIRM) begin
                        req_d.valid = 1'b1;
                        req_d.op = fcsr_pkg::FCSR_OP_ERASE;
                        state_d = FCSR_BUSY;
                    end else begin
                        state_d = FCSR_READY;
                    end
                end
                FCSR_FACTORY_SETUP: begin
                    if (code == fcsr_pkg::CMD_CONFIRM) begin
                        req_d.valid = 1'b1;
                        req_d.op = fcsr_pkg::FCSR_OP_FACTORY;
                        state_d = FCSR_FACTORY_BUSY;
                    end else begin
                        state_d = FCSR_READY;
                    end
                end
                FCSR_FACTORY_BUSY: begin
                    if (factory_accept) begin
                        req_d.valid = 1'b1;
                        req_d.op = fcsr_pkg::FCSR_OP_FACTORY_DATA;
                    end
                end
                FCSR_LOCK_SETUP: begin
                    req_d.valid = 1'b1;
                    case (code)
                        fcsr_pkg::CMD_LOCK: req_d.op = fcsr_pkg::FCSR_OP_LOCK;
                        fcsr_pkg::CMD_CONFIRM:
                            req_d.op = fcsr_pkg::FCSR_OP_UNLOCK;
                        fcsr_pkg::CMD_LOCK_DOWN:
                            req_d.op = fcsr_pkg::FCSR_OP_LOCK_DOWN;
                        fcsr_pkg::CMD_CFG_WRITE:
                            req_d.op = fcsr_pkg::FCSR_OP_CFG_WRITE;
                        default: req_d.valid = 1'b0;
                    endcase
                    state_d = FCSR_READY;
                end
                FCSR_BUSY: begin
                    if (code == fcsr_pkg::CMD_SUSPEND) begin
                        req_d.valid = 1'b1;
                        req_d.op = fcsr_pkg::FCSR_OP_SUSPEND;
                        state_d = FCSR_PROG_SUSP;
                    end
                end
                FCSR_PROG_SUSP: begin
                    if (code == fcsr_pkg::CMD_CONFIRM) begin
                        req_d.valid = 1'b1;
                        req_d.op = fcsr_pkg::FCSR_OP_RESUME;
                        state_d = FCSR_BUSY;
                    end else if (code == fcsr_pkg::CMD_ERASE) begin
                        state_d = FCSR_PROG_SUSP_ERASE_SETUP;
                    end
                end
                FCSR_PROG_SUSP_ERASE_SETUP: begin
                    // Ambiguous confirm dropped, program stays suspended
                    state_d = FCSR_PROG_SUSP;
                end
                default: state_d = FCSR_READY;
            endcase
        end else if (i_array_done &&
                     (state_q == FCSR_BUSY ||
                      state_q == FCSR_FACTORY_BUSY)) begin
            state_d = FCSR_READY;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= FCSR_READY;
            req_q <= '0;
            idle_q <= 1'b1;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            idle_q <= state_d == FCSR_READY;
        end
    end

    // Block address of the opening cycle held for the sequence
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            first_cycle_block_address_q <= '0;
        end else if (i_write.valid && state_q == FCSR_READY) begin
            first_cycle_block_address_q <= blk_addr;
        end
    end

    // Error bits: array reports set, clear only when idle; set wins
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            err_q <= fcsr_pkg::ERR_RESET;
        end else if (i_write.valid && code == fcsr_pkg::CMD_CLEAR_STATUS &&
                     state_q == FCSR_READY && clear_ok) begin
            err_q <= i_array_err;
        end else begin
            err_q <= err_q | i_array_err;
        end
    end

    // Per-partition output selector, last command decides
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int p = 0; p < fcsr_pkg::PARTS; p++) begin
                sel_q[p] <= fcsr_pkg::FCSR_OUT_ARRAY;
            end
            last_part_q <= '0;
        end else if (i_write.valid) begin
            last_part_q <= wr_part;
            if (!legal || in_setup) begin
                sel_q[wr_part] <= fcsr_pkg::FCSR_OUT_STATUS;
            end else begin
                case (code)
                    fcsr_pkg::CMD_READ_ARRAY:
                        sel_q[wr_part] <= fcsr_pkg::FCSR_OUT_ARRAY;
                    fcsr_pkg::CMD_READ_ID:
                        sel_q[wr_part] <= fcsr_pkg::FCSR_OUT_ID;
                    fcsr_pkg::CMD_READ_QUERY:
                        sel_q[wr_part] <= fcsr_pkg::FCSR_OUT_QUERY;
                    fcsr_pkg::CMD_READ_STATUS, fcsr_pkg::CMD_PROGRAM,
                    fcsr_pkg::CMD_PROGRAM_ALT, fcsr_pkg::CMD_ERASE,
                    fcsr_pkg::CMD_FACTORY, fcsr_pkg::CMD_OTP_SETUP,
                    fcsr_pkg::CMD_LOCK_SETUP:
                        sel_q[wr_part] <= fcsr_pkg::FCSR_OUT_STATUS;
                    default: sel_q[wr_part] <= sel_q[wr_part];
                endcase
            end
        end
    end

    // Read path: invalid only for array reads of the last written partition while busy
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            read_valid_q <= 1'b0;
            read_sel_q <= fcsr_pkg::FCSR_OUT_ARRAY;
            read_query_q <= 1'b0;
        end else begin
            read_sel_q <= sel_q[rd_part];
            read_valid_q <= !(sel_q[rd_part] == fcsr_pkg::FCSR_OUT_ARRAY &&
                              machine_busy && rd_part == last_part_q);
            read_query_q <= sel_q[rd_part] == fcsr_pkg::FCSR_OUT_QUERY;
        end
    end

    assign o_req = req_q;
    assign o_err = err_q;
    assign o_idle = idle_q;
    assign o_read_valid = read_valid_q;
    assign o_read_sel = read_sel_q;
    assign o_read_query = read_query_q;

    sequence s_susp_erase_confirm;
        state_q == FCSR_PROG_SUSP_ERASE_SETUP && i_write.valid &&
        code == fcsr_pkg::CMD_CONFIRM;
    endsequence

    AST_SUSP_IGNORE: assert property (@(posedge i_clk) disable iff (i_reset)
        s_susp_erase_confirm |=> !req_q.valid && state_q == FCSR_PROG_SUSP)
        else $error("confirm after erase setup in suspend not ignored");

    AST_LOCK_READY: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == FCSR_LOCK_SETUP && i_write.valid |=> state_q == FCSR_READY)
        else $error("lock confirm did not return to ready");

    AST_FACTORY_DROP: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == FCSR_FACTORY_BUSY && i_write.valid && i_factory_status_bit
        |=> !req_q.valid)
        else $error("factory data accepted while status bit set");

    AST_CLEAR_BUSY: assert property (@(posedge i_clk) disable iff (i_reset)
        machine_busy && i_array_err == 4'h0 |=> err_q == $past(err_q))
        else $error("error bits changed while busy");

    AST_BLOCK_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q != FCSR_READY |=> $stable(first_cycle_block_address_q))
        else $error("stored block address changed mid sequence");

    AST_ILLEGAL: assert property (@(posedge i_clk) disable iff (i_reset)
        i_write.valid && !legal |=> sel_q[$past(wr_part)] ==
        fcsr_pkg::FCSR_OUT_STATUS)
        else $error("illegal code did not select status");

    AST_ID_SEL: assert property (@(posedge i_clk) disable iff (i_reset)
        i_write.valid && legal && state_q == FCSR_READY &&
        code == fcsr_pkg::CMD_READ_ID |=> sel_q[$past(wr_part)] ==
        fcsr_pkg::FCSR_OUT_ID ##1 read_query_q == 1'b0 ||
        rd_part != $past(wr_part, 2))
        else $error("identifier selection not kept");

    AST_DONE_READY: assert property (@(posedge i_clk) disable iff (i_reset)
        state_q == FCSR_BUSY && i_array_done && !i_write.valid
        |=> state_q == FCSR_READY && o_idle)
        else $error("completion did not return to ready");
endmodule // fcsr_core

// [fcsr_pkg.sv]
/*
 Package for the flash command interpreter: command codes, operation codes,
 output selector codes, bus write and array request carriers.
 Assumes a single clock domain and a bus interface already synchronised.
*/
package fcsr_pkg;

    localparam int PART_BITS = 3;
    localparam int PARTS = 8;
    localparam int ADDR_BITS = 24;
    localparam int BLOCK_LSB = 16;
    localparam int ID_SPACE_BASE = 24'h00_0000;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0] CMD_BUF_PROGRAM = 8'he8;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_FACTORY = 8'h80;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_DOWN = 8'h2f;
    localparam logic [7:0] CMD_CFG_WRITE = 8'h03;
    localparam int STATUS_FACTORY_BIT = 0;
    localparam logic [3:0] ERR_RESET = 4'h0;

    typedef enum logic [1:0] {
        FCSR_OUT_ARRAY,
        FCSR_OUT_ID,
        FCSR_OUT_QUERY,
        FCSR_OUT_STATUS
    } fcsr_out_type;

    typedef enum logic [3:0] {
        FCSR_OP_NONE,
        FCSR_OP_PROGRAM,
        FCSR_OP_ERASE,
        FCSR_OP_FACTORY,
        FCSR_OP_OTP,
        FCSR_OP_LOCK,
        FCSR_OP_UNLOCK,
        FCSR_OP_LOCK_DOWN,
        FCSR_OP_CFG_WRITE,
        FCSR_OP_SUSPEND,
        FCSR_OP_RESUME,
        FCSR_OP_FACTORY_DATA
    } fcsr_op_type;

    typedef struct packed {
        logic valid;
        logic [ADDR_BITS-1:0] addr;
        logic [15:0] data;
    } fcsr_write_type;

    typedef struct packed {
        logic valid;
        fcsr_op_type op;
        logic [ADDR_BITS-1:0] block_addr;
        logic [ADDR_BITS-1:0] addr;
        logic [15:0] data;
    } fcsr_req_type;

endpackage

// [fcsr_cmd_decode.sv]
/*
 Command code classifier for the flash command interpreter.
 Assumes the code is the low byte of the bus write data.
*/
`timescale 1ns/1ps
module fcsr_cmd_decode (
    input wire logic [7:0] i_code,
    output logic o_legal
);
    wire logic is_prog;
    wire logic is_misc;
    wire logic is_lock;
    assign is_prog = (i_code == fcsr_pkg::CMD_PROGRAM) ||
                     (i_code == fcsr_pkg::CMD_PROGRAM_ALT) ||
                     (i_code == fcsr_pkg::CMD_BUF_PROGRAM) ||
                     (i_code == fcsr_pkg::CMD_ERASE) ||
                     (i_code == fcsr_pkg::CMD_FACTORY) ||
                     (i_code == fcsr_pkg::CMD_OTP_SETUP);
    assign is_misc = (i_code == fcsr_pkg::CMD_READ_ARRAY) ||
                     (i_code == fcsr_pkg::CMD_CONFIRM) ||
                     (i_code == fcsr_pkg::CMD_SUSPEND) ||
                     (i_code == fcsr_pkg::CMD_READ_STATUS) ||
                     (i_code == fcsr_pkg::CMD_CLEAR_STATUS) ||
                     (i_code == fcsr_pkg::CMD_READ_ID) ||
                     (i_code == fcsr_pkg::CMD_READ_QUERY);
    assign is_lock = (i_code == fcsr_pkg::CMD_LOCK_SETUP) ||
                     (i_code == fcsr_pkg::CMD_LOCK) ||
                     (i_code == fcsr_pkg::CMD_LOCK_DOWN) ||
                     (i_code == fcsr_pkg::CMD_CFG_WRITE);
    // Anything outside the permitted set is illegal
    assign o_legal = is_prog || is_misc || is_lock;
endmodule // fcsr_cmd_decode

// [fcsr_array_model.sv]
/*
 Behavioural model of the flash array controller beside the command
 interpreter. Assumes requests arrive as one-cycle pulses on i_clk.
*/
`timescale 1ns/1ps
module fcsr_array_model #(
    parameter int LAT = 24
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire fcsr_pkg::fcsr_req_type i_req,
    input wire logic [3:0] i_err_inject,
    output logic o_busy,
    output logic o_done,
    output logic [3:0] o_err
);
    int count_q;
    logic hold_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            count_q <= 0;
            hold_q <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= (count_q == 1) && !hold_q;
            if (i_req.valid) begin
                case (i_req.op)
                    fcsr_pkg::FCSR_OP_PROGRAM,
                    fcsr_pkg::FCSR_OP_ERASE,
                    fcsr_pkg::FCSR_OP_OTP: count_q <= LAT;
                    fcsr_pkg::FCSR_OP_FACTORY: count_q <= 5 * LAT;
                    fcsr_pkg::FCSR_OP_SUSPEND: hold_q <= 1'b1;
                    fcsr_pkg::FCSR_OP_RESUME: hold_q <= 1'b0;
                    default: ;
                endcase
            end else if (count_q != 0 && !hold_q) begin
                count_q <= count_q - 1;
            end
        end
    end

    // Errors only ride on the completion pulse
    assign o_busy = (count_q != 0) && !hold_q;
    assign o_err = o_done ? i_err_inject : 4'h0;
endmodule // fcsr_array_model

// [flash_command_state_rules_tb_top.sv]
/*
 Self-checking testbench of the flash command interpreter with an array
 controller model. Assumes the core and its package are compiled first.
*/
`timescale 1ns/1ps
module flash_command_state_rules_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fcsr_pkg::fcsr_write_type wr = '0;
    logic busy, done, idle, rvalid, rquery;
    logic factory_bit = 1'b0;
    logic [3:0] err_inj = 4'h0;
    logic [3:0] aerr, err;
    logic [23:0] raddr = 24'h00_0000;
    fcsr_pkg::fcsr_req_type req, last_req;
    fcsr_pkg::fcsr_out_type sel;
    int n_mismatch = 0;
    int checks_done = 0;
    int req_cnt = 0;
    int cycles = 0;

    fcsr_core dut (.i_clk(clk), .i_reset(rst), .i_write(wr),
        .i_array_busy(busy), .i_array_done(done), .i_array_err(aerr),
        .i_factory_status_bit(factory_bit), .i_read_addr(raddr), .o_req(req),
        .o_err(err), .o_idle(idle), .o_read_valid(rvalid),
        .o_read_sel(sel), .o_read_query(rquery));
    fcsr_array_model #(.LAT(24)) far (.i_clk(clk), .i_reset(rst),
        .i_req(req), .i_err_inject(err_inj), .o_busy(busy), .o_done(done),
        .o_err(aerr));

    always #4 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (req.valid === 1'b1) begin
            last_req <= req;
            req_cnt <= req_cnt + 1;
        end
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_v(logic [23:0] got, logic [23:0] exp, string m);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic chk_op(fcsr_pkg::fcsr_op_type got,
            fcsr_pkg::fcsr_op_type exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t request kind", $time);
        end
    endtask

    function automatic logic [23:0] pa(int p, int o);
        return {p[2:0], o[20:0]};
    endfunction

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_wr(logic [23:0] a, logic [15:0] d);
        @(posedge clk);
        wr <= '{valid: 1'b1, addr: a, data: d};
        @(posedge clk);
        wr.valid <= 1'b0;
    endtask

    task automatic cmd(logic [23:0] a, logic [7:0] c);
        bus_wr(a, {8'h00, c});
    endtask

    task automatic look(logic [23:0] a);
        @(posedge clk);
        raddr <= a;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic expect_req(int b, fcsr_pkg::fcsr_op_type op);
        repeat (2) @(posedge clk);
        #1;
        chk_v(24'(req_cnt - b), 24'h00_0001, "request count");
        chk_op(last_req.op, op);
    endtask

    task automatic no_req(int b);
        repeat (3) @(posedge clk);
        #1;
        chk_v(24'(req_cnt - b), 24'h00_0000, "unexpected request");
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (!(idle === 1'b1 && busy === 1'b0) && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) chk_v(24'h00_0000, 24'h00_0001, "stuck busy");
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        for (int p = 0; p < 8; p++) begin
            look(pa(p, 0));
            chk_v(24'(sel), 24'(fcsr_pkg::FCSR_OUT_ARRAY), "rst sel");
        end
        chk_v(24'(idle), 24'h00_0001, "not ready after reset");
        chk_v(24'(err), 24'h00_0000, "errors after reset");
    endtask

    task automatic t_sel();
        fcsr_pkg::fcsr_out_type want [4];
        logic [7:0] conf [4];
        fcsr_pkg::fcsr_op_type ops [4];
        int b;
        want = '{fcsr_pkg::FCSR_OUT_ARRAY, fcsr_pkg::FCSR_OUT_ID,
            fcsr_pkg::FCSR_OUT_QUERY, fcsr_pkg::FCSR_OUT_STATUS};
        conf = '{fcsr_pkg::CMD_LOCK, fcsr_pkg::CMD_CONFIRM,
            fcsr_pkg::CMD_LOCK_DOWN, fcsr_pkg::CMD_CFG_WRITE};
        ops = '{fcsr_pkg::FCSR_OP_LOCK, fcsr_pkg::FCSR_OP_UNLOCK,
            fcsr_pkg::FCSR_OP_LOCK_DOWN, fcsr_pkg::FCSR_OP_CFG_WRITE};
        do_reset();
        cmd(pa(1, 0), fcsr_pkg::CMD_READ_ID);
        cmd(pa(2, 0), fcsr_pkg::CMD_READ_QUERY);
        cmd(pa(3, 0), fcsr_pkg::CMD_READ_STATUS);
        for (int p = 0; p < 4; p++) begin
            look(pa(p, 0));
            chk_v(24'(sel), 24'(want[p]), "partition selector");
            chk_v(24'(rquery), 24'(p == 2), "query space");
        end
        // Selectors now differ per partition while two-cycle ops run
        for (int i = 0; i < 4; i++) begin
            b = req_cnt;
            cmd(pa(i, 21'h02_0000), fcsr_pkg::CMD_LOCK_SETUP);
            cmd(pa(i, 21'h02_0042), conf[i]);
            expect_req(b, ops[i]);
            chk_v(24'(last_req.block_addr[23:16]), 24'(pa(i, 21'h02_0000)
                >> 16), "block address");
            chk_v(24'(idle), 24'h00_0001, "not ready");
        end
        b = req_cnt;
        cmd(pa(0, 0), fcsr_pkg::CMD_LOCK_SETUP);
        cmd(pa(0, 0), fcsr_pkg::CMD_PROGRAM);
        no_req(b);
    endtask

    task automatic t_prog();
        logic [23:0] a;
        int b;
        a = pa(5, 21'h01_0100);
        do_reset();
        b = req_cnt;
        cmd(a, fcsr_pkg::CMD_ERASE);
        cmd(a, 8'h33);
        no_req(b);
        cmd(a, fcsr_pkg::CMD_ERASE);
        cmd(a, fcsr_pkg::CMD_CONFIRM);
        expect_req(b, fcsr_pkg::FCSR_OP_ERASE);
        wait_idle();
        err_inj <= 4'h2;
        b = req_cnt;
        cmd(a, fcsr_pkg::CMD_PROGRAM);
        bus_wr(a, 16'hbeef);
        expect_req(b, fcsr_pkg::FCSR_OP_PROGRAM);
        chk_v(24'(last_req.data), 24'h00_beef, "program data");
        cmd(a, fcsr_pkg::CMD_READ_ARRAY);
        look(a);
        chk_v(24'(rvalid), 24'h00_0000, "busy read valid");
        look(pa(6, 0));
        chk_v(24'(rvalid), 24'h00_0001, "idle read invalid");
        wait_idle();
        chk_v(24'(err), 24'h00_0002, "error not kept");
        err_inj <= 4'h0;
        cmd(a, fcsr_pkg::CMD_PROGRAM);
        bus_wr(a, 16'h1234);
        cmd(a, fcsr_pkg::CMD_CLEAR_STATUS);
        repeat (2) @(posedge clk);
        chk_v(24'(err), 24'h00_0002, "cleared while busy");
        wait_idle();
        cmd(a, fcsr_pkg::CMD_CLEAR_STATUS);
        repeat (2) @(posedge clk);
        chk_v(24'(err), 24'h00_0000, "not cleared when idle");
    endtask

    task automatic t_susp();
        logic [23:0] a;
        int b;
        a = pa(4, 21'h03_0000);
        do_reset();
        cmd(a, fcsr_pkg::CMD_PROGRAM);
        bus_wr(a, 16'h5555);
        cmd(a, fcsr_pkg::CMD_SUSPEND);
        repeat (4) @(posedge clk);
        b = req_cnt;
        cmd(a, fcsr_pkg::CMD_ERASE);
        cmd(a, fcsr_pkg::CMD_CONFIRM);
        no_req(b);
    endtask

    task automatic t_factory();
        logic [23:0] a;
        int b;
        a = pa(2, 21'h04_0000);
        do_reset();
        b = req_cnt;
        cmd(a, fcsr_pkg::CMD_FACTORY);
        cmd(a, fcsr_pkg::CMD_CONFIRM);
        expect_req(b, fcsr_pkg::FCSR_OP_FACTORY);
        b = req_cnt;
        bus_wr(a, 16'h1234);
        expect_req(b, fcsr_pkg::FCSR_OP_FACTORY_DATA);
        chk_v(24'(last_req.data), 24'h00_1234, "factory data");
        @(posedge clk);
        factory_bit <= 1'b1;
        b = req_cnt;
        bus_wr(a, 16'h4321);
        no_req(b);
        @(posedge clk);
        factory_bit <= 1'b0;
        wait_idle();
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_sel();
        t_prog();
        t_susp();
        t_factory();
        complete_run();
    end
endmodule // flash_command_state_rules_tb_top
